// *** hdl/err_diag_pkg.sv ***
package err_diag_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_S * CLK_FREQ_HZ;
	localparam int TICK_W = 28;

	// ****************************************************************
	// register offsets (byte addresses, one word each)
	// ****************************************************************
	localparam logic [5:0] OFS_ERR_CFG = 6'h00;
	localparam logic [5:0] OFS_HOLD_HIGH = 6'h04;
	localparam logic [5:0] OFS_HOLD_LOW = 6'h08;
	localparam logic [5:0] OFS_IRQ_STATUS = 6'h0c;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h10;
	localparam logic [5:0] OFS_IND_CFG = 6'h14;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int BIT_STROBE = 0;
	localparam int BIT_MODE = 1;
	localparam int SRC_LSB = 2;
	localparam int BIT_TICK = 0;
	localparam int BIT_OVF = 1;
	localparam int RX_SEL_LSB = 0;
	localparam int TX_SEL_LSB = 4;
	localparam int BIT_RX_NRZ = 8;
	localparam int BIT_RX_SLICED = 9;
	localparam int BIT_TX_NRZ = 10;
	localparam int BIT_TX_RZ = 11;

	// ****************************************************************
	// reset values and count limit
	// ****************************************************************
	localparam logic [4:0] ERR_CFG_RST = 5'h00;
	localparam logic [1:0] IRQ_MASK_RST = 2'h3;
	localparam logic [11:0] IND_CFG_RST = 12'h000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	// ****************************************************************
	// encodings
	// ****************************************************************
	typedef enum logic [2:0] {
		SRC_RX_VIOL = 3'h0, SRC_RX_EXZ = 3'h1, SRC_RX_BOTH = 3'h2, SRC_TX_VIOL = 3'h3,
		SRC_TX_EXZ = 3'h4, SRC_TX_BOTH = 3'h5, SRC_PATTERN = 3'h6, SRC_RESERVED = 3'h7
	} count_src_e;

	typedef enum logic [2:0] {
		IND_SYNC = 3'h0, IND_ALARM = 3'h1, IND_LEVEL_A = 3'h2, IND_LEVEL_B = 3'h3,
		IND_EXZ = 3'h4, IND_VIOL = 3'h5, IND_BOTH = 3'h6, IND_LOSS = 3'h7
	} ind_sel_e;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic rx_line_violation;
		logic rx_line_excess_zeroes;
		logic tx_sys_violation;
		logic tx_sys_excess_zeroes;
		logic pattern_error;
	} error_events_s;

	typedef struct packed {
		logic pattern_sync;
		logic pattern_error;
		logic rx_line_alarm;
		logic pos_sliced;
		logic neg_sliced;
		logic recovered_clock;
		logic rx_line_signal_loss;
	} rx_status_s;

	typedef struct packed {
		logic pattern_sync;
		logic pattern_error;
		logic tx_sys_alarm;
		logic tx_overcurrent;
		logic tx_line_signal_loss;
		logic tx_sys_signal_loss;
	} tx_status_s;

endpackage

// *** hdl/line_error_counter_and_status_mux.sv ***
// Overview of operation
// - one 16-bit error accumulator counts one configured error type
// - 3-bit source field picks one of seven error sources
// - transmit violation sources count nothing in transmit single-rail NRZ mode
// - accumulator buffered into hold registers; mode bit one auto, zero manual
// - auto mode updates hold registers every second from master clock timer
// - each second sets tick flag; interrupt unless tick mask blocks
// - at expiry copy count to hold registers and clear accumulator
// - manual mode: strobe rising edge copies count and clears accumulator
// - error at all-ones count sets overflow flag; interrupt unless masked
// - buffered count readable as high and low registers
// - rx indicator replaces neg-rail pin in NRZ, clock pin in sliced
// - 3-bit rx select chooses what the rx indicator shows
// - rx select 000: high in sync, low one cycle per error
// - rx select 001 follows line alarm, 111 follows line signal loss
// - rx select 011 outputs recovered clock, 010 sliced data xor
// - rx selects 100/101/110 pulse high per exz, violation, either
// - tx indicator replaces tx neg-rail pin in NRZ and dual-rail RZ
// - 3-bit tx select chooses what the tx indicator shows
// - tx NRZ mode disables violation, combined and system loss choices
// - tx select 000: high in sync, low one cycle per error
// - tx selects 001/010/011/111 follow alarm, overcurrent, line loss, sys loss
// - tx selects 100/101/110 pulse high per exz, violation, either
`timescale 1ns/1ps
`default_nettype none

module line_error_counter_and_status_mux
	import err_diag_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [5:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// detector inputs
	input wire error_events_s events,
	input wire rx_status_s rx_status,
	input wire tx_status_s tx_status,
	// data to be shared with the indicator pins
	input wire logic rx_neg_rail_data,
	input wire logic rx_clock_data,
	input wire logic tx_neg_rail_data,
	// pins and interrupt
	output logic rx_neg_rail_pin,
	output logic rx_recovered_clock_pin,
	output logic tx_neg_rail_pin,
	output logic irq
);

	// ****************************************************************
	// helpers
	// ****************************************************************

	// merge write data into a register by byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// indicator selection shared by receive and transmit pins
	function automatic logic pick_indicator(input logic [2:0] sel, input logic sync,
		input logic perr, input logic lvl1, input logic lvl2, input logic lvl3,
		input logic exz, input logic viol, input logic lvl7);
		logic r;
		r = 1'b0;
		case (sel)
			IND_SYNC: r = sync & ~perr;
			IND_ALARM: r = lvl1;
			IND_LEVEL_A: r = lvl2;
			IND_LEVEL_B: r = lvl3;
			IND_EXZ: r = exz;
			IND_VIOL: r = viol;
			IND_BOTH: r = exz | viol;
			default: r = lvl7;
		endcase
		return r;
	endfunction

	// increment for one cycle of events
	// source decode, nrz gate
	function automatic logic [1:0] count_step(input logic [2:0] src, input error_events_s ev,
		input logic tx_nrz);
		logic [1:0] r;
		r = 2'h0;
		case (src)
			SRC_RX_VIOL: r = {1'b0, ev.rx_line_violation};
			SRC_RX_EXZ: r = {1'b0, ev.rx_line_excess_zeroes};
			SRC_RX_BOTH: r = 2'({1'b0, ev.rx_line_violation})
				+ 2'({1'b0, ev.rx_line_excess_zeroes});
			SRC_TX_VIOL: r = {1'b0, ev.tx_sys_violation & ~tx_nrz};
			SRC_TX_EXZ: r = {1'b0, ev.tx_sys_excess_zeroes};
			SRC_TX_BOTH: r = tx_nrz ? 2'h0 : 2'({1'b0, ev.tx_sys_violation})
				+ 2'({1'b0, ev.tx_sys_excess_zeroes});
			SRC_PATTERN: r = {1'b0, ev.pattern_error};
			default: r = 2'h0;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	logic [4:0] err_cfg;
	logic [1:0] irq_mask;
	logic [11:0] ind_cfg;
	logic second_tick_flag;
	logic count_overflow_flag;
	logic [15:0] accum;
	logic [15:0] hold;
	logic [TICK_W-1:0] tick_count;
	logic [4:0] next_err_cfg;
	logic [1:0] next_irq_mask;
	logic [11:0] next_ind_cfg;
	logic next_second_tick_flag;
	logic next_count_overflow_flag;
	logic [15:0] next_accum;
	logic [15:0] next_hold;
	logic [TICK_W-1:0] next_tick_count;
	logic [31:0] next_readdata;
	logic next_waitrequest;
	logic next_irq;
	logic next_rx_neg;
	logic next_rx_clk;
	logic next_tx_neg;

	logic update_mode;
	logic [2:0] count_source_sel;
	logic [2:0] rx_indicator_sel;
	logic [2:0] tx_indicator_sel;
	logic rx_nrz;
	logic rx_sliced;
	logic tx_nrz;
	logic tx_rz;
	logic wr_go;
	logic tick;
	logic strobe_rise;
	logic transfer;
	logic [1:0] step;
	logic [16:0] sum;
	logic [31:0] wmerge;
	logic [31:0] ind_merge;
	logic rx_indicator_pin;
	logic tx_indicator_pin;

	assign update_mode = err_cfg[BIT_MODE];
	assign count_source_sel = err_cfg[SRC_LSB +: 3];
	assign rx_indicator_sel = ind_cfg[RX_SEL_LSB +: 3];
	assign tx_indicator_sel = ind_cfg[TX_SEL_LSB +: 3];
	assign rx_nrz = ind_cfg[BIT_RX_NRZ];
	assign rx_sliced = ind_cfg[BIT_RX_SLICED];
	assign tx_nrz = ind_cfg[BIT_TX_NRZ];
	assign tx_rz = ind_cfg[BIT_TX_RZ];
	assign wr_go = write & ~waitrequest;

	// ****************************************************************
	// one-second timer and counting
	// ****************************************************************

	assign tick = (tick_count == TICK_W'(TICK_CYCLES_P - 1));

	// strobe rising edge in manual mode
	assign wmerge = lane_merge({27'h0, err_cfg}, writedata, byteenable);
	assign ind_merge = lane_merge({20'h0, ind_cfg}, writedata, byteenable);
	assign strobe_rise = wr_go && (address == OFS_ERR_CFG) && !update_mode
		&& !err_cfg[BIT_STROBE] && wmerge[BIT_STROBE];

	assign transfer = update_mode ? tick : strobe_rise;

	assign step = count_step(count_source_sel, events, tx_nrz);
	assign sum = {1'b0, accum} + {15'h0, step};

	// next values of timer, accumulator, hold and flags
	always_comb begin
		next_tick_count = tick ? '0 : tick_count + TICK_W'(1);
		next_hold = hold;
		next_accum = accum;
		next_count_overflow_flag = count_overflow_flag;
		next_second_tick_flag = second_tick_flag;
		if (sum[16]) begin
			next_accum = COUNT_MAX;
		end else begin
			next_accum = sum[15:0];
		end
		if (transfer) begin
			next_hold = accum;
			next_accum = {14'h0, step};
		end
		// software clears by writing one; hardware set wins below
		if (wr_go && address == OFS_IRQ_STATUS) begin
			if (byteenable[0] && writedata[BIT_TICK]) begin
				next_second_tick_flag = 1'b0;
			end
			if (byteenable[0] && writedata[BIT_OVF]) begin
				next_count_overflow_flag = 1'b0;
			end
		end
		if (tick) begin
			next_second_tick_flag = 1'b1;
		end
		// overflow when full and another error arrives
		if (!transfer && step != 2'h0 && sum[16]) begin
			next_count_overflow_flag = 1'b1;
		end
	end

	// register timer, accumulator, hold and flags
	always_ff @(posedge clk) begin
		if (reset) begin
			tick_count <= '0;
			accum <= 16'h0000;
			hold <= 16'h0000;
			second_tick_flag <= 1'b0;
			count_overflow_flag <= 1'b0;
		end else begin
			tick_count <= next_tick_count;
			accum <= next_accum;
			hold <= next_hold;
			second_tick_flag <= next_second_tick_flag;
			count_overflow_flag <= next_count_overflow_flag;
		end
	end

	// ****************************************************************
	// register bus
	// ****************************************************************

	// next values of configuration and bus answer
	always_comb begin
		next_err_cfg = err_cfg;
		next_irq_mask = irq_mask;
		next_ind_cfg = ind_cfg;
		next_readdata = readdata;
		// one wait cycle, then a one-cycle answer
		next_waitrequest = !((read | write) && waitrequest);
		if (wr_go) begin
			if (address == OFS_ERR_CFG) begin
				next_err_cfg = wmerge[4:0];
			end else if (address == OFS_IRQ_MASK) begin
				next_irq_mask = byteenable[0] ? writedata[1:0] : irq_mask;
			end else if (address == OFS_IND_CFG) begin
				next_ind_cfg = ind_merge[11:0];
			end
		end
		if (read && waitrequest) begin
			// hold count as high and low bytes
			if (address == OFS_ERR_CFG) begin
				next_readdata = {27'h0, err_cfg};
			end else if (address == OFS_HOLD_HIGH) begin
				next_readdata = {24'h0, hold[15:8]};
			end else if (address == OFS_HOLD_LOW) begin
				next_readdata = {24'h0, hold[7:0]};
			end else if (address == OFS_IRQ_STATUS) begin
				next_readdata = {30'h0, count_overflow_flag, second_tick_flag};
			end else if (address == OFS_IRQ_MASK) begin
				next_readdata = {30'h0, irq_mask};
			end else if (address == OFS_IND_CFG) begin
				next_readdata = {20'h0, ind_cfg};
			end else begin
				next_readdata = 32'h0000_0000;
			end
		end
	end

	// register configuration and bus answer
	always_ff @(posedge clk) begin
		if (reset) begin
			err_cfg <= ERR_CFG_RST;
			irq_mask <= IRQ_MASK_RST;
			ind_cfg <= IND_CFG_RST;
			readdata <= 32'h0000_0000;
			waitrequest <= 1'b1;
		end else begin
			err_cfg <= next_err_cfg;
			irq_mask <= next_irq_mask;
			ind_cfg <= next_ind_cfg;
			readdata <= next_readdata;
			waitrequest <= next_waitrequest;
		end
	end

	// ****************************************************************
	// indicator pins and interrupt
	// ****************************************************************

	assign rx_indicator_pin = pick_indicator(rx_indicator_sel, rx_status.pattern_sync,
		rx_status.pattern_error, rx_status.rx_line_alarm,
		rx_status.pos_sliced ^ rx_status.neg_sliced, rx_status.recovered_clock,
		events.rx_line_excess_zeroes, events.rx_line_violation,
		rx_status.rx_line_signal_loss);

	// tx selection; nrz disables 101 to 111; per code
	assign tx_indicator_pin = (tx_nrz && tx_indicator_sel >= IND_VIOL) ? 1'b0 :
		pick_indicator(tx_indicator_sel, tx_status.pattern_sync,
		tx_status.pattern_error, tx_status.tx_sys_alarm, tx_status.tx_overcurrent,
		tx_status.tx_line_signal_loss, events.tx_sys_excess_zeroes,
		events.tx_sys_violation, tx_status.tx_sys_signal_loss);

	// next values of pins and interrupt
	always_comb begin
		next_rx_neg = rx_nrz ? rx_indicator_pin : rx_neg_rail_data;
		next_rx_clk = rx_sliced ? rx_indicator_pin : rx_clock_data;
		next_tx_neg = (tx_nrz | tx_rz) ? tx_indicator_pin : tx_neg_rail_data;
		next_irq = (second_tick_flag & ~irq_mask[BIT_TICK])
			| (count_overflow_flag & ~irq_mask[BIT_OVF]);
	end

	// register pins and interrupt
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_neg_rail_pin <= 1'b0;
			rx_recovered_clock_pin <= 1'b0;
			tx_neg_rail_pin <= 1'b0;
			irq <= 1'b0;
		end else begin
			rx_neg_rail_pin <= next_rx_neg;
			rx_recovered_clock_pin <= next_rx_clk;
			tx_neg_rail_pin <= next_tx_neg;
			irq <= next_irq;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_count_single: assert property (!transfer && accum < 16'hfff0 && step == 2'h1
		|=> accum == $past(accum) + 16'h0001) else $error("accumulator missed an event");
	a_tx_nrz_quiet: assert property (tx_nrz && count_source_sel == SRC_TX_VIOL
		&& !transfer |=> accum == $past(accum)) else $error("nrz violation counted");
	a_auto_copy: assert property (update_mode && tick
		|=> hold == $past(accum) && accum <= 16'h0002) else $error("auto copy wrong");
	a_manual_copy: assert property (strobe_rise
		|=> hold == $past(accum)) else $error("manual copy wrong");
	a_tick_flag: assert property (tick |=> second_tick_flag)
		else $error("tick flag not set");
	a_irq_gate: assert property (second_tick_flag && !irq_mask[BIT_TICK]
		|=> irq) else $error("unmasked tick no interrupt");
	a_overflow_set: assert property (accum == COUNT_MAX && step != 2'h0 && !transfer
		|=> count_overflow_flag && accum == COUNT_MAX) else $error("overflow missed");
	a_rx_sync_pin: assert property (rx_nrz && rx_indicator_sel == IND_SYNC
		&& rx_status.pattern_error |=> !rx_neg_rail_pin) else $error("rx error not low");
	a_tx_disabled: assert property (tx_nrz && tx_indicator_sel == IND_LOSS
		|=> !tx_neg_rail_pin) else $error("tx nrz choice not disabled");
	a_rx_pin_share: assert property (!rx_nrz |=> rx_neg_rail_pin == $past(rx_neg_rail_data))
		else $error("rx pin not data");
	a_bus_answer: assert property ((read | write) && waitrequest |=> !waitrequest)
		else $error("no bus answer");

	c_auto_tick: cover property (update_mode && tick && accum != 16'h0000);
	c_manual: cover property (strobe_rise);
	c_overflow: cover property (count_overflow_flag && irq);

endmodule // line_error_counter_and_status_mux

`default_nettype wire

// *** verif/line_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_side_model
	import err_diag_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// burst request
	input wire logic go,
	input wire logic [4:0] mask,
	input wire logic [15:0] num,
	output logic busy,
	// detector side toward the block
	output error_events_s events,
	output rx_status_s rx_status,
	output tx_status_s tx_status,
	output logic rx_neg_rail_data,
	output logic rx_clock_data,
	output logic tx_neg_rail_data
);
	logic [15:0] left;
	logic [4:0] held;
	logic [7:0] walk;
	assign busy = (left != 16'h0000);
	// one event set per cycle while a burst runs, status levels keep walking
	always_ff @(posedge clk) begin
		if (reset) begin
			left <= 16'h0000;
			held <= 5'h00;
			walk <= 8'h00;
			events <= '0;
		end else begin
			walk <= walk + 8'h01;
			events <= busy ? error_events_s'(held) : '0;
			if (go) begin
				left <= num;
				held <= mask;
			end else if (busy) begin
				left <= left - 16'h0001;
			end
		end
	end
	// status levels and pin data derived from the walk, so every level toggles
	always_comb begin
		rx_status = {walk[3], walk[2:0] == 3'h5, walk[4], walk[1], walk[2], walk[0], walk[5]};
		tx_status = {walk[4], walk[2:0] == 3'h3, walk[5], walk[3], walk[6], walk[1]};
		rx_neg_rail_data = walk[7];
		rx_clock_data = ~walk[0];
		tx_neg_rail_data = walk[6] ^ walk[0];
	end
endmodule // line_side_model
`default_nettype wire

// *** verif/tb_line_error_counter_and_status_mux.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_line_error_counter_and_status_mux;
	import err_diag_pkg::*;
	localparam int unsigned TICK_P = 60;
	logic clk, reset, read, write, go, busy, rx_nd, rx_cd, tx_nd, rx_pin, rc_pin, tx_pin, irq;
	logic [5:0] address;
	logic [31:0] writedata, readdata, rd, rd2;
	logic [3:0] byteenable;
	logic waitrequest;
	logic [4:0] mask;
	logic [15:0] num;
	error_events_s events;
	rx_status_s rx_status;
	tx_status_s tx_status;
	int error_cnt, checks_done;
	int cyc = 0;

	// ****************************************************************
	// instances
	// ****************************************************************
	line_error_counter_and_status_mux #(.TICK_CYCLES_P(TICK_P)) u_dut (.clk(clk), .reset(reset),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
		.events(events), .rx_status(rx_status), .tx_status(tx_status),
		.rx_neg_rail_data(rx_nd), .rx_clock_data(rx_cd), .tx_neg_rail_data(tx_nd),
		.rx_neg_rail_pin(rx_pin), .rx_recovered_clock_pin(rc_pin), .tx_neg_rail_pin(tx_pin),
		.irq(irq));
	line_side_model u_side (.clk(clk), .reset(reset), .go(go), .mask(mask), .num(num),
		.busy(busy), .events(events), .rx_status(rx_status), .tx_status(tx_status),
		.rx_neg_rail_data(rx_nd), .rx_clock_data(rx_cd), .tx_neg_rail_data(tx_nd));

	// ****************************************************************
	// clock, timeout and verdict
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t timeout", $time);
			give_verdict();
		end
	end

	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t word got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic got, input logic exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %0t pin got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic burst(input logic [4:0] m, input logic [15:0] n, input bit wait_end);
		@(posedge clk);
		go <= 1'b1;
		mask <= m;
		num <= n;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (wait_end && busy) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask
	task automatic wait_tick();
		bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
		do bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000); while (rd[BIT_TICK] !== 1'b1);
	endtask
	task automatic read_hold(input logic [15:0] exp);
		bus(1'b0, OFS_HOLD_HIGH, 32'h0000_0000);
		rd2 = rd;
		bus(1'b0, OFS_HOLD_LOW, 32'h0000_0000);
		check_word(rd2, {24'h00_0000, exp[15:8]}); // high byte
		check_word(rd, {24'h00_0000, exp[7:0]}); // low byte
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic test_reset();
		check_pin(irq, 1'b0); // idle line
		bus(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
		check_word(rd, 32'h0000_0003); // masks set
		bus(1'b0, OFS_ERR_CFG, 32'h0000_0000);
		check_word(rd, 32'h0000_0000); // manual default
		bus(1'b1, OFS_HOLD_LOW, 32'h0000_0055);
		read_hold(16'h0000); // read only
		bus(1'b0, 6'h18, 32'h0000_0000);
		check_word(rd, 32'h0000_0000);
		byteenable <= 4'he;
		bus(1'b1, OFS_IND_CFG, 32'h0000_0fff);
		bus(1'b0, OFS_IND_CFG, 32'h0000_0000);
		check_word(rd, 32'h0000_0f00); // mode bits by lane
		byteenable <= 4'hf;
		bus(1'b1, OFS_IND_CFG, 32'h0000_0000);
	endtask
	task automatic test_auto();
		bus(1'b1, OFS_ERR_CFG, 32'h0000_0002);
		wait_tick();
		burst(5'h10, 16'h0007, 1'b1);
		wait_tick();
		read_hold(16'h0007); // second update
		wait_tick();
		read_hold(16'h0000); // counter cleared
		check_pin(irq, 1'b0); // tick masked
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
		wait_tick();
		repeat (2) @(posedge clk);
		check_pin(irq, 1'b1); // tick unmasked
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
		repeat (2) @(posedge clk);
		check_pin(irq, 1'b0); // tick masked
	endtask
	task automatic test_count(input logic [2:0] src, input logic nrz, input logic [15:0] exp);
		bus(1'b1, OFS_IND_CFG, {21'h00_0000, nrz, 10'h000});
		bus(1'b1, OFS_ERR_CFG, {27'h000_0000, src, 2'h0});
		bus(1'b1, OFS_ERR_CFG, {27'h000_0000, src, 2'h1});
		burst(5'h10, 16'h0001, 1'b1);
		burst(5'h08, 16'h0002, 1'b1);
		burst(5'h04, 16'h0003, 1'b1);
		burst(5'h02, 16'h0004, 1'b1);
		burst(5'h01, 16'h0005, 1'b1);
		burst(5'h1f, 16'h0006, 1'b1);
		bus(1'b1, OFS_ERR_CFG, {27'h000_0000, src, 2'h0});
		bus(1'b1, OFS_ERR_CFG, {27'h000_0000, src, 2'h1});
		read_hold(exp); // source count
	endtask
	task automatic test_overflow();
		bus(1'b1, OFS_ERR_CFG, 32'h0000_0000);
		bus(1'b1, OFS_ERR_CFG, 32'h0000_0001);
		bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
		burst(5'h10, 16'hffff, 1'b1);
		bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
		check_pin(rd[BIT_OVF], 1'b0); // full but no overflow
		burst(5'h10, 16'h0001, 1'b1);
		bus(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
		check_pin(rd[BIT_OVF], 1'b1); // one more error
		check_pin(irq, 1'b0); // overflow masked
		bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge clk);
		check_pin(irq, 1'b1); // overflow unmasked
		bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0002);
		repeat (2) @(posedge clk);
		check_pin(irq, 1'b0); // flag cleared
		bus(1'b1, OFS_ERR_CFG, 32'h0000_0000);
		bus(1'b1, OFS_ERR_CFG, 32'h0000_0001);
		read_hold(COUNT_MAX); // all ones held
	endtask
	function automatic logic ind_exp(input logic tx, input logic nrz, input logic [2:0] s,
			input rx_status_s r, input tx_status_s t, input error_events_s e);
		logic ex, vi;
		ex = tx ? e.tx_sys_excess_zeroes : e.rx_line_excess_zeroes;
		vi = tx ? e.tx_sys_violation : e.rx_line_violation;
		if (tx && nrz && s >= 3'h5) return 1'b0;
		case (s)
			3'h0: return tx ? t.pattern_sync & ~t.pattern_error : r.pattern_sync & ~r.pattern_error;
			3'h1: return tx ? t.tx_sys_alarm : r.rx_line_alarm;
			3'h2: return tx ? t.tx_overcurrent : r.pos_sliced ^ r.neg_sliced;
			3'h3: return tx ? t.tx_line_signal_loss : r.recovered_clock;
			3'h4: return ex;
			3'h5: return vi;
			3'h6: return ex | vi;
			default: return tx ? t.tx_sys_signal_loss : r.rx_line_signal_loss;
		endcase
	endfunction
	task automatic test_ind(input logic [3:0] md, input logic [2:0] s);
		rx_status_s pr;
		tx_status_s pt;
		error_events_s pe;
		logic prn, pcd, ptn;
		bus(1'b1, OFS_IND_CFG, {20'h0_0000, md, 1'b0, s, 1'b0, s});
		burst(s[0] ? 5'h12 : 5'h0c, 16'h000c, 1'b0);
		for (int k = 0; k < 24; k++) begin
			@(posedge clk);
			if (k > 0) begin
				check_pin(rx_pin, md[0] ? ind_exp(1'b0, 1'b0, s, pr, pt, pe) : prn);
				check_pin(rc_pin, md[1] ? ind_exp(1'b0, 1'b0, s, pr, pt, pe) : pcd);
				check_pin(tx_pin, (md[2] | md[3]) ? ind_exp(1'b1, md[2], s, pr, pt, pe) : ptn);
			end
			pr = rx_status;
			pt = tx_status;
			pe = events;
			prn = rx_nd;
			pcd = rx_cd;
			ptn = tx_nd;
		end
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0000_0000;
		byteenable = 4'hf;
		go = 1'b0;
		mask = 5'h00;
		num = 16'h0000;
		error_cnt = 0;
		checks_done = 0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_auto();
		test_count(3'h0, 1'b0, 16'h0007);
		test_count(3'h1, 1'b0, 16'h0008);
		test_count(3'h2, 1'b0, 16'h000f);
		test_count(3'h3, 1'b0, 16'h0009);
		test_count(3'h4, 1'b0, 16'h000a);
		test_count(3'h5, 1'b0, 16'h0013);
		test_count(3'h6, 1'b0, 16'h000b);
		test_count(3'h7, 1'b0, 16'h0000);
		test_count(3'h3, 1'b1, 16'h0000);
		test_count(3'h5, 1'b1, 16'h0000);
		test_overflow();
		for (int i = 0; i < 8; i++) begin
			test_ind(4'h5, 3'(i));
			test_ind(4'ha, 3'(i));
		end
		test_ind(4'h0, 3'h6);
		give_verdict();
	end
endmodule // tb_line_error_counter_and_status_mux
`default_nettype wire
